// ==== design/hsr_pkg.sv ====
// Package for the high-resolution status and identification register bank
`default_nettype none
package hsr_pkg;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 8;
   localparam logic [7:0] OFF_RES_LSB = 8'h38;
   localparam logic [7:0] OFF_RES_MID = 8'h39;
   localparam logic [7:0] OFF_RES_MSB = 8'h3A;
   localparam logic [7:0] OFF_STATUS = 8'h3B;
   localparam logic [7:0] OFF_IRQ_STAT = 8'h3C;
   localparam logic [7:0] OFF_IRQ_MASK = 8'h3D;
   localparam logic [7:0] OFF_PART_REV = 8'h3E;
   localparam logic [7:0] OFF_FAMILY = 8'h3F;
   localparam int BIT_ZC = 4;
   localparam int BIT_OR = 3;
   localparam int BIT_UR = 2;
   localparam int BIT_OF = 1;
   localparam int BIT_PEND_N = 0;
   localparam logic [7:0] STATUS_RST = 8'h00;
   localparam logic [7:0] ZERO8 = 8'h00;
   // Interrupt bits: 0 new result, 1 error seen on a refresh
   localparam int IRQ_NEW = 0;
   localparam int IRQ_ERR = 1;
   localparam logic [1:0] IRQ_RST = 2'h0;
   localparam logic [23:0] RES_RST = 24'h000000;
   // Arbitrary neutral identity values
   localparam logic [4:0] PART_CODE = 5'h15;
   localparam logic [2:0] REV_CODE = 3'h5;
   localparam logic [7:0] FAMILY_CODE = 8'h5A;

   typedef struct packed {
      logic zero_count;
      logic over_range;
      logic under_range;
      logic overflow;
   } hsr_err_t;

   typedef struct packed {
      logic [23:0] data;
      hsr_err_t err;
   } hsr_result_t;
endpackage
`default_nettype wire

// ==== design/hsr_regs.sv ====
// High-resolution conversion status, result and identification registers
//
// Contract
// - Zero-count flag, status bit 4, reports no sensor cycles counted.
// - Over-range flag, status bit 3, reports sensor above reference frequency.
// - Under-range flag, status bit 2, reports negative code from large offset.
// - Overflow flag, status bit 1, reports sensor too near reference frequency.
// - Error flags refresh only after reading the lowest result byte.
// - Each error flag reads 1 if it occurred for last result read.
// - Bit 0 goes low at conversion end, high again on low-byte read.
// - Revision register gives fixed part code 7:3 and revision 2:0.
// - Family register gives a fixed eight-bit family code.
`default_nettype none
module hsr_regs #(
   parameter int DATA_W = 8, // Register width
   parameter int ADDR_W = 8 // Address width
) (
   input wire logic clk_i, // 25 MHz clock
   input wire logic nrst_i, // Synchronous reset, active low
   input wire logic conv_done_i, // Conversion end pulse
   input wire hsr_pkg::hsr_result_t conv_result_i, // Result and errors, valid with done
   input wire logic [7:0] addr_i, // Register address
   input wire logic [7:0] wdata_i, // Write data
   input wire logic wr_i, // Write strobe
   input wire logic rd_i, // Read strobe
   output logic [7:0] rdata_o, // Read data, cycle after rd_i
   output logic irq_o // Level interrupt
);
   hsr_pkg::hsr_result_t latest_reg;
   logic [23:0] shown_reg;
   hsr_pkg::hsr_err_t err_reg;
   logic pend_n_reg;
   logic [1:0] irq_stat_reg;
   logic [1:0] irq_mask_reg;
   logic [23:0] upper_reg;
   logic [7:0] rdata_next;
   logic lsb_rd;
   logic [7:0] status_val;
   logic [1:0] irq_set;

   // Map and ports are byte wide; other widths are not served
   if (DATA_W != hsr_pkg::DATA_W) begin : g_bad_data_w
      $error("hsr_regs serves only an eight-bit data width");
   end
   if (ADDR_W != hsr_pkg::ADDR_W) begin : g_bad_addr_w
      $error("hsr_regs serves only an eight-bit address width");
   end

   assign lsb_rd = rd_i && (addr_i == hsr_pkg::OFF_RES_LSB);

   // Newest conversion, held until the next conversion end
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         latest_reg <= '{data: hsr_pkg::RES_RST, err: '0};
      end else if (conv_done_i) begin
         latest_reg <= conv_result_i;
      end
   end

   // Low-byte read snapshots data and errors so mid and high stay coherent
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         shown_reg <= hsr_pkg::RES_RST;
         err_reg <= '0;
      end else if (lsb_rd) begin
         shown_reg <= latest_reg.data;
         err_reg <= latest_reg.err;
      end
   end

   // Conversion end wins over a same-cycle low-byte read
   // Reset value follows the status reset word, so bit 0 starts low
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         pend_n_reg <= hsr_pkg::STATUS_RST[hsr_pkg::BIT_PEND_N];
      end else if (conv_done_i) begin
         pend_n_reg <= 1'b0;
      end else if (lsb_rd) begin
         pend_n_reg <= 1'b1;
      end
   end

   assign status_val = {3'b000, err_reg.zero_count, err_reg.over_range,
                        err_reg.under_range, err_reg.overflow, pend_n_reg};

   assign irq_set[hsr_pkg::IRQ_NEW] = conv_done_i;
   assign irq_set[hsr_pkg::IRQ_ERR] = lsb_rd && (latest_reg.err != '0);

   // Sticky events, write one to clear; a new event beats the clear
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         irq_stat_reg <= hsr_pkg::IRQ_RST;
      end else begin
         irq_stat_reg <= (irq_stat_reg & ~((wr_i && addr_i == hsr_pkg::OFF_IRQ_STAT)
                         ? wdata_i[1:0] : 2'h0)) | irq_set;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         irq_mask_reg <= hsr_pkg::IRQ_RST;
      end else if (wr_i && addr_i == hsr_pkg::OFF_IRQ_MASK) begin
         irq_mask_reg <= wdata_i[1:0];
      end
   end

   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         irq_o <= 1'b0;
      end else begin
         irq_o <= |(irq_stat_reg & irq_mask_reg);
      end
   end

   // Mid and high bytes serve from the snapshot
   // Only 0x3C and 0x3D decode writes; status and codes ignore them
   always_comb begin
      rdata_next = hsr_pkg::ZERO8;
      case (addr_i)
         hsr_pkg::OFF_RES_LSB: rdata_next = latest_reg.data[7:0];
         hsr_pkg::OFF_RES_MID: rdata_next = shown_reg[15:8];
         hsr_pkg::OFF_RES_MSB: rdata_next = shown_reg[23:16];
         hsr_pkg::OFF_STATUS: rdata_next = status_val;
         hsr_pkg::OFF_IRQ_STAT: rdata_next = {6'h00, irq_stat_reg};
         hsr_pkg::OFF_IRQ_MASK: rdata_next = {6'h00, irq_mask_reg};
         hsr_pkg::OFF_PART_REV: rdata_next = {hsr_pkg::PART_CODE, hsr_pkg::REV_CODE};
         hsr_pkg::OFF_FAMILY: rdata_next = hsr_pkg::FAMILY_CODE;
         default: rdata_next = hsr_pkg::ZERO8;
      endcase
   end

   // Data stand only in the cycle after the read strobe
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         rdata_o <= hsr_pkg::ZERO8;
      end else if (rd_i) begin
         rdata_o <= rdata_next;
      end else begin
         rdata_o <= hsr_pkg::ZERO8;
      end
   end

   // Helper: previous strobe state for assertions
   logic prev_rd_reg;
   logic [7:0] prev_addr_reg;
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         prev_rd_reg <= 1'b0;
         prev_addr_reg <= hsr_pkg::ZERO8;
      end else begin
         prev_rd_reg <= rd_i;
         prev_addr_reg <= addr_i;
      end
   end

   AST_ERR_REFRESH: assert property (@(posedge clk_i) disable iff (!nrst_i)
      !lsb_rd |=> $stable(err_reg)) else $error("error flags changed without low-byte read");

   AST_ZC_FLAG: assert property (@(posedge clk_i) disable iff (!nrst_i)
      lsb_rd && latest_reg.err.zero_count |=> status_val[hsr_pkg::BIT_ZC])
      else $error("zero-count flag not set");

   AST_OR_FLAG: assert property (@(posedge clk_i) disable iff (!nrst_i)
      lsb_rd |=> status_val[hsr_pkg::BIT_OR] == $past(latest_reg.err.over_range))
      else $error("over-range flag wrong");

   AST_UR_FLAG: assert property (@(posedge clk_i) disable iff (!nrst_i)
      lsb_rd |=> status_val[hsr_pkg::BIT_UR] == $past(latest_reg.err.under_range))
      else $error("under-range flag wrong");

   AST_OF_FLAG: assert property (@(posedge clk_i) disable iff (!nrst_i)
      lsb_rd && !latest_reg.err.overflow |=> !status_val[hsr_pkg::BIT_OF])
      else $error("overflow flag wrong");

   AST_ERR_CLEAR: assert property (@(posedge clk_i) disable iff (!nrst_i)
      lsb_rd && latest_reg.err == '0 |=> status_val[4:1] == 4'h0)
      else $error("error flags not cleared for clean result");

   AST_PEND_LOW: assert property (@(posedge clk_i) disable iff (!nrst_i)
      conv_done_i |=> !pend_n_reg ##1 (!pend_n_reg || $past(lsb_rd)))
      else $error("pending flag not held low after conversion");

   AST_PEND_HIGH: assert property (@(posedge clk_i) disable iff (!nrst_i)
      lsb_rd && !conv_done_i |=> pend_n_reg) else $error("pending flag not released");

   AST_UNUSED_BITS: assert property (@(posedge clk_i) disable iff (!nrst_i)
      prev_rd_reg && prev_addr_reg == hsr_pkg::OFF_STATUS |-> rdata_o[7:5] == 3'b000)
      else $error("unused status bits not zero");

   AST_REV_READ: assert property (@(posedge clk_i) disable iff (!nrst_i)
      rd_i && addr_i == hsr_pkg::OFF_PART_REV
      |=> rdata_o == {hsr_pkg::PART_CODE, hsr_pkg::REV_CODE})
      else $error("revision register wrong");

   AST_FAMILY_READ: assert property (@(posedge clk_i) disable iff (!nrst_i)
      rd_i && addr_i == hsr_pkg::OFF_FAMILY |=> rdata_o == hsr_pkg::FAMILY_CODE)
      else $error("family register wrong");

   AST_WRITE_IGNORED: assert property (@(posedge clk_i) disable iff (!nrst_i)
      wr_i && !rd_i && !conv_done_i |=> $stable(status_val))
      else $error("write changed status");

   AST_IRQ_LEVEL: assert property (@(posedge clk_i) disable iff (!nrst_i)
      |(irq_stat_reg & irq_mask_reg) |=> irq_o) else $error("interrupt not raised");

   AST_ZC_CLEAR: assert property (@(posedge clk_i) disable iff (!nrst_i)
      lsb_rd && !latest_reg.err.zero_count |=> !status_val[hsr_pkg::BIT_ZC])
      else $error("zero-count flag set for clean result");

   AST_OR_SET: assert property (@(posedge clk_i) disable iff (!nrst_i)
      lsb_rd && latest_reg.err.over_range |=> status_val[hsr_pkg::BIT_OR])
      else $error("over-range flag not set");

   AST_UR_SET: assert property (@(posedge clk_i) disable iff (!nrst_i)
      lsb_rd && latest_reg.err.under_range |=> status_val[hsr_pkg::BIT_UR])
      else $error("under-range flag not set");

   AST_OF_SET: assert property (@(posedge clk_i) disable iff (!nrst_i)
      lsb_rd && latest_reg.err.overflow |=> status_val[hsr_pkg::BIT_OF])
      else $error("overflow flag not set");

   AST_ZC_HOLD: assert property (@(posedge clk_i) disable iff (!nrst_i)
      !lsb_rd |=> $stable(err_reg.zero_count))
      else $error("zero-count flag moved without low-byte read");

   AST_OR_HOLD: assert property (@(posedge clk_i) disable iff (!nrst_i)
      !lsb_rd |=> $stable(err_reg.over_range))
      else $error("over-range flag moved without low-byte read");

   AST_UR_HOLD: assert property (@(posedge clk_i) disable iff (!nrst_i)
      !lsb_rd |=> $stable(err_reg.under_range))
      else $error("under-range flag moved without low-byte read");

   AST_OF_HOLD: assert property (@(posedge clk_i) disable iff (!nrst_i)
      !lsb_rd |=> $stable(err_reg.overflow))
      else $error("overflow flag moved without low-byte read");

   AST_ERR_SNAPSHOT: assert property (@(posedge clk_i) disable iff (!nrst_i)
      lsb_rd |=> err_reg == $past(latest_reg.err))
      else $error("error flags do not match result read");

   AST_PEND_CONV: assert property (@(posedge clk_i) disable iff (!nrst_i)
      conv_done_i |=> !pend_n_reg)
      else $error("pending flag not low after conversion");

   AST_PEND_STAY: assert property (@(posedge clk_i) disable iff (!nrst_i)
      !pend_n_reg && !lsb_rd |=> !pend_n_reg)
      else $error("pending flag released without low-byte read");

   AST_PEND_IDLE: assert property (@(posedge clk_i) disable iff (!nrst_i)
      pend_n_reg && !conv_done_i |=> pend_n_reg)
      else $error("pending flag dropped without conversion");

   AST_STATUS_READ: assert property (@(posedge clk_i) disable iff (!nrst_i)
      prev_rd_reg && prev_addr_reg == hsr_pkg::OFF_STATUS |-> rdata_o == $past(status_val))
      else $error("status read data wrong");

   AST_LSB_READ: assert property (@(posedge clk_i) disable iff (!nrst_i)
      rd_i && addr_i == hsr_pkg::OFF_RES_LSB |=> rdata_o == $past(latest_reg.data[7:0]))
      else $error("low byte read data wrong");

   AST_MID_READ: assert property (@(posedge clk_i) disable iff (!nrst_i)
      rd_i && addr_i == hsr_pkg::OFF_RES_MID |=> rdata_o == $past(shown_reg[15:8]))
      else $error("mid byte read data wrong");

   AST_MSB_READ: assert property (@(posedge clk_i) disable iff (!nrst_i)
      rd_i && addr_i == hsr_pkg::OFF_RES_MSB |=> rdata_o == $past(shown_reg[23:16]))
      else $error("high byte read data wrong");

   AST_SNAP_HOLD: assert property (@(posedge clk_i) disable iff (!nrst_i)
      !lsb_rd |=> $stable(shown_reg))
      else $error("result snapshot moved without low-byte read");

   AST_SNAP_LOAD: assert property (@(posedge clk_i) disable iff (!nrst_i)
      lsb_rd |=> shown_reg == $past(latest_reg.data))
      else $error("result snapshot not loaded");

   AST_RDATA_IDLE: assert property (@(posedge clk_i) disable iff (!nrst_i)
      !rd_i |=> rdata_o == hsr_pkg::ZERO8)
      else $error("read data not zero outside read");

   AST_UNMAPPED_READ: assert property (@(posedge clk_i) disable iff (!nrst_i)
      rd_i && addr_i > hsr_pkg::OFF_FAMILY |=> rdata_o == hsr_pkg::ZERO8)
      else $error("unmapped read not zero");

   AST_WRITE_PEND: assert property (@(posedge clk_i) disable iff (!nrst_i)
      wr_i && !rd_i && !conv_done_i |=> $stable(pend_n_reg))
      else $error("write changed pending flag");

   AST_WRITE_SNAP: assert property (@(posedge clk_i) disable iff (!nrst_i)
      wr_i && !rd_i |=> $stable(shown_reg))
      else $error("write changed result snapshot");

   AST_LATEST_HOLD: assert property (@(posedge clk_i) disable iff (!nrst_i)
      !conv_done_i |=> $stable(latest_reg))
      else $error("newest result moved without conversion");

   AST_MASK_HOLD: assert property (@(posedge clk_i) disable iff (!nrst_i)
      !(wr_i && addr_i == hsr_pkg::OFF_IRQ_MASK) |=> $stable(irq_mask_reg))
      else $error("interrupt mask moved without write");

   AST_MASK_LOAD: assert property (@(posedge clk_i) disable iff (!nrst_i)
      wr_i && addr_i == hsr_pkg::OFF_IRQ_MASK |=> irq_mask_reg == $past(wdata_i[1:0]))
      else $error("interrupt mask not loaded");

   AST_IRQ_NEW_SET: assert property (@(posedge clk_i) disable iff (!nrst_i)
      conv_done_i |=> irq_stat_reg[hsr_pkg::IRQ_NEW])
      else $error("new-result event not recorded");

   AST_IRQ_ERR_SET: assert property (@(posedge clk_i) disable iff (!nrst_i)
      lsb_rd && latest_reg.err != '0 |=> irq_stat_reg[hsr_pkg::IRQ_ERR])
      else $error("error event not recorded");

   AST_IRQ_LOW: assert property (@(posedge clk_i) disable iff (!nrst_i)
      !(|(irq_stat_reg & irq_mask_reg)) |=> !irq_o)
      else $error("interrupt raised with nothing pending");

   AST_IRQ_CLEAR: assert property (@(posedge clk_i) disable iff (!nrst_i)
      wr_i && addr_i == hsr_pkg::OFF_IRQ_STAT && wdata_i[0] && !conv_done_i
      |=> !irq_stat_reg[hsr_pkg::IRQ_NEW])
      else $error("new-result event not cleared");

   AST_NEW_STICKY: assert property (@(posedge clk_i) disable iff (!nrst_i)
      irq_stat_reg[hsr_pkg::IRQ_NEW] && !(wr_i && addr_i == hsr_pkg::OFF_IRQ_STAT && wdata_i[0])
      |=> irq_stat_reg[hsr_pkg::IRQ_NEW])
      else $error("new-result event lost");

   AST_ERR_STICKY: assert property (@(posedge clk_i) disable iff (!nrst_i)
      irq_stat_reg[hsr_pkg::IRQ_ERR] && !(wr_i && addr_i == hsr_pkg::OFF_IRQ_STAT && wdata_i[1])
      |=> irq_stat_reg[hsr_pkg::IRQ_ERR])
      else $error("error event lost");

   AST_NEW_QUIET: assert property (@(posedge clk_i) disable iff (!nrst_i)
      !irq_stat_reg[hsr_pkg::IRQ_NEW] && !conv_done_i |=> !irq_stat_reg[hsr_pkg::IRQ_NEW])
      else $error("spurious new-result event");

   AST_ERR_QUIET: assert property (@(posedge clk_i) disable iff (!nrst_i)
      !irq_stat_reg[hsr_pkg::IRQ_ERR] && !lsb_rd |=> !irq_stat_reg[hsr_pkg::IRQ_ERR])
      else $error("spurious error event");
endmodule // hsr_regs
`default_nettype wire

// ==== dv/tb.sv ====
// Self-checking testbench for the high-resolution status and identification bank
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_i = 1'b0;
   logic nrst_i = 1'b0;
   logic conv_done_i = 1'b0;
   hsr_pkg::hsr_result_t conv_result_i = '0;
   logic [7:0] addr_i = 8'h00;
   logic [7:0] wdata_i = 8'h00;
   logic wr_i = 1'b0;
   logic rd_i = 1'b0;
   logic [7:0] rdata_o;
   logic irq_o;
   int n_errors = 0;
   int comparisons = 0;

   hsr_regs dut (.clk_i(clk_i), .nrst_i(nrst_i), .conv_done_i(conv_done_i),
      .conv_result_i(conv_result_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
      .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o));

   initial begin
      forever #20 clk_i = ~clk_i;
   end

   task automatic report_and_stop();
      $display("errors %0d comparisons %0d", n_errors, comparisons);
      if (n_errors == 0 && comparisons > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
      comparisons++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge clk_i);
      wr_i <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe
   task automatic rdchk(input logic [7:0] a, input logic [7:0] exp, input string what);
      @(posedge clk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge clk_i);
      rd_i <= 1'b0;
      #1 chk(rdata_o, exp, what);
   endtask

   task automatic conv(input logic [23:0] d, input logic [3:0] e);
      @(posedge clk_i);
      conv_done_i <= 1'b1;
      conv_result_i <= {d, e};
      @(posedge clk_i);
      conv_done_i <= 1'b0;
   endtask

   // Registered output lags its cause by one cycle
   task automatic chk_irq(input logic exp, input string what);
      repeat (2) @(posedge clk_i);
      #1 chk({7'h00, irq_o}, {7'h00, exp}, what);
   endtask

   task automatic t_ident();
      rdchk(hsr_pkg::OFF_STATUS, hsr_pkg::STATUS_RST, "status reset");
      rdchk(hsr_pkg::OFF_PART_REV, {hsr_pkg::PART_CODE, hsr_pkg::REV_CODE}, "part");
      rdchk(hsr_pkg::OFF_FAMILY, hsr_pkg::FAMILY_CODE, "family");
      rdchk(8'h40, 8'h00, "unmapped");
   endtask

   task automatic t_irq();
      wr(hsr_pkg::OFF_IRQ_STAT, 8'h03);
      conv(24'h000001, 4'h0);
      chk_irq(1'b0, "masked irq");
      rdchk(hsr_pkg::OFF_IRQ_STAT, 8'h01, "irq status");
      wr(hsr_pkg::OFF_IRQ_MASK, 8'h01);
      chk_irq(1'b1, "unmasked irq");
      wr(hsr_pkg::OFF_IRQ_STAT, 8'h01);
      chk_irq(1'b0, "cleared irq");
      wr(hsr_pkg::OFF_IRQ_MASK, 8'h00);
   endtask

   // Flags must stay on the old result until the low byte is read
   task automatic t_hold();
      rdchk(hsr_pkg::OFF_RES_LSB, 8'h01, "drain");
      conv(24'h123456, 4'b1010);
      rdchk(hsr_pkg::OFF_STATUS, 8'h00, "pending, old flags");
      rdchk(hsr_pkg::OFF_RES_LSB, 8'h56, "low byte");
      rdchk(hsr_pkg::OFF_STATUS, 8'h15, "flags refreshed");
      rdchk(hsr_pkg::OFF_IRQ_STAT, 8'h03, "irq error event");
      rdchk(hsr_pkg::OFF_RES_MID, 8'h34, "mid byte");
      rdchk(hsr_pkg::OFF_RES_MSB, 8'h12, "high byte");
   endtask

   task automatic t_each();
      logic [3:0] e;
      for (int i = 0; i < 5; i++) begin
         e = (i < 4) ? (4'h1 << i) : 4'h0;
         conv({16'h0000, 8'(i)}, e);
         rdchk(hsr_pkg::OFF_RES_LSB, 8'(i), "each low");
         rdchk(hsr_pkg::OFF_STATUS, {3'h0, e, 1'b1}, "each flag");
      end
   endtask

   task automatic t_writes();
      wr(hsr_pkg::OFF_STATUS, 8'hFF);
      wr(hsr_pkg::OFF_PART_REV, 8'h00);
      wr(hsr_pkg::OFF_FAMILY, 8'h00);
      rdchk(hsr_pkg::OFF_STATUS, 8'h01, "status after write");
      rdchk(hsr_pkg::OFF_PART_REV, {hsr_pkg::PART_CODE, hsr_pkg::REV_CODE}, "part w");
      rdchk(hsr_pkg::OFF_FAMILY, hsr_pkg::FAMILY_CODE, "family after write");
   endtask

   initial begin
      repeat (5000) @(posedge clk_i);
      n_errors++;
      $display("mismatch at %0t: watchdog expired", $time);
      report_and_stop();
   end

   initial begin
      repeat (3) @(posedge clk_i);
      nrst_i <= 1'b1;
      t_ident();
      t_irq();
      t_hold();
      t_each();
      t_writes();
      report_and_stop();
   end
endmodule // tb
`default_nettype wire
